// >>> hie_pkg.sv
// Package: register map, event bit positions, reset values and timing counts for the event block
`default_nettype none

package hie_pkg;

    // Register byte offsets
    localparam logic [7:0] HIE_OFS_EVT_SET = 8'h80;
    localparam logic [7:0] HIE_OFS_EVT_CLR = 8'h84;
    localparam logic [7:0] HIE_OFS_MASK = 8'h88;
    localparam logic [7:0] HIE_OFS_LINK_CTRL = 8'h8C;
    localparam logic [7:0] HIE_OFS_HOST_CTRL = 8'h90;
    localparam logic [7:0] HIE_OFS_PHY_DATA = 8'h94;

    // Event bit positions inside pending_events
    localparam int HIE_BIT_EEPROM = 30;
    localparam int HIE_BIT_SOFT = 29;
    localparam int HIE_BIT_LATE_ACK = 27;
    localparam int HIE_BIT_PHY_BYTE = 26;
    localparam int HIE_BIT_OVERLONG = 25;
    localparam int HIE_BIT_FATAL = 24;
    localparam int HIE_BIT_MISMATCH = 23;
    localparam int HIE_BIT_MISSED = 22;
    localparam int HIE_BIT_BOUNDARY = 20;

    // Control field positions
    localparam int HIE_BIT_MASTER_EN = 21;
    localparam int HIE_BIT_ACK_EN = 0;
    localparam int HIE_PHY_LSB = 0;
    localparam int HIE_SEC_MSB = 31;
    localparam int HIE_SEC_LSB = 25;
    localparam int HIE_TICK_MSB = 24;
    localparam int HIE_TICK_LSB = 12;

    // Bits that exist in pending_events; 31 and 28 are reserved and read zero
    localparam logic [31:0] HIE_EVT_IMPL = 32'h6FD0_0000;

    // Reset values
    localparam logic [31:0] HIE_RST_EVT = 32'h0000_0000;
    localparam logic [31:0] HIE_RST_MASK = 32'h0000_0000;
    localparam logic HIE_RST_MASTER_EN = 1'b0;
    localparam logic HIE_RST_ACK_EN = 1'b0;

    // AXI responses
    localparam logic [1:0] HIE_RESP_OKAY = 2'b00;
    localparam logic [1:0] HIE_RESP_SLVERR = 2'b10;

    // Timing
    localparam int HIE_CLK_PERIOD_NS = 25;
    localparam int HIE_OVERLONG_NS = 125000;
    localparam int HIE_OVERLONG_CYC = HIE_OVERLONG_NS / HIE_CLK_PERIOD_NS;

endpackage

`default_nettype wire

// >>> hie_event_ctrl.sv
// Interrupt event collection logic with an AXI4-Lite register slave
//
// Design decision made here: register access over AXI4-Lite.
`default_nettype none

// Notes on behaviour
// - Event bit sets on rising edge of its source or software writing 1 to set.
// - Event bits clear only by software writing 1 to the clear register.
// - Reading the set register returns raw pending events.
// - Reading the clear register returns pending events ANDed with event mask.
// - Bits 31 and 28 always read as zero.
// - Bit 30 raised when serial EEPROM configuration load finishes.
// - Bit 29 has no hardware source; software sets and clears it only.
// - With late-ack enable, bit 27 raised on FIFO data, busy responder or tardy ack.
// - Bit 26 raised on PHY register byte arrival; byte readable afterwards.
// - With period master enabled, bit 25 raised when start-to-gap exceeds 125 us.
// - Overlong-period event clears the period master enable bit.
// - Bit 24 raised on any halting error, such as a context halting.
// - While bit 24 set, normal events of the faulting contexts are blocked.
// - Bit 23 raised when received cycle start disagrees with local timer fields.
// - Bit 22 raised when no cycle start occurs between two boundary events.
// - Missed-period may be raised early on prediction from gap ordering.
// - Boundary event on toggle of timer tick LSB; sets bit 20.
module hie_event_ctrl
    import hie_pkg::*;
#(
    parameter int NCTX = 4,
    parameter int OVERLONG_CYC = hie_pkg::HIE_OVERLONG_CYC
)(
    input wire logic CLK_I,                         // 40 MHz bus clock
    input wire logic RSTN_I,                        // Async reset, active low
    input wire logic [7:0] S_AXI_AWADDR_I,          // Write address
    input wire logic S_AXI_AWVALID_I,               // Write address valid
    output logic S_AXI_AWREADY_O,                   // Write address ready
    input wire logic [31:0] S_AXI_WDATA_I,          // Write data
    input wire logic [3:0] S_AXI_WSTRB_I,           // Write byte strobes
    input wire logic S_AXI_WVALID_I,                // Write data valid
    output logic S_AXI_WREADY_O,                    // Write data ready
    output logic [1:0] S_AXI_BRESP_O,               // Write response
    output logic S_AXI_BVALID_O,                    // Write response valid
    input wire logic S_AXI_BREADY_I,                // Write response ready
    input wire logic [7:0] S_AXI_ARADDR_I,          // Read address
    input wire logic S_AXI_ARVALID_I,               // Read address valid
    output logic S_AXI_ARREADY_O,                   // Read address ready
    output logic [31:0] S_AXI_RDATA_O,              // Read data
    output logic [1:0] S_AXI_RRESP_O,               // Read response
    output logic S_AXI_RVALID_O,                    // Read data valid
    input wire logic S_AXI_RREADY_I,                // Read data ready
    input wire logic EEPROM_DONE_I,                 // EEPROM load finished, level
    input wire logic RXFIFO_PENDING_I,              // Receive data awaits host delivery
    input wire logic PHYRESP_BUSY_I,                // Physical response unit busy
    input wire logic ACK_TARDY_SENT_I,              // An ack_tardy was sent
    input wire logic PHY_BYTE_VALID_I,              // PHY register byte present
    input wire logic [7:0] PHY_BYTE_I,              // PHY register byte
    input wire logic [31:0] TIMER_I,                // Local cycle timer value
    input wire logic CS_TX_START_I,                 // Cycle start send begins, pulse
    input wire logic CS_RX_I,                       // Cycle start received, pulse
    input wire logic [6:0] CS_RX_SEC_I,             // Received seconds value
    input wire logic [12:0] CS_RX_TICK_I,           // Received tick value
    input wire logic SUBGAP_END_I,                  // Subaction gap ended, pulse
    input wire logic ARB_RESET_GAP_I,               // Arbitration reset gap seen, pulse
    input wire logic [NCTX-1:0] CTX_HALT_I,         // Context halted status, level
    input wire logic [NCTX-1:0] CTX_EVT_I,          // Normal context events, pulse
    output logic [NCTX-1:0] CTX_EVT_O,              // Context events after blocking
    output logic PERIOD_MASTER_EN_O,                // Period master enable to link
    output logic IRQ_O                              // Level interrupt
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [31:0] pend;
        logic [31:0] mask;
        logic master_en;
        logic ack_en;
        logic [7:0] phy_byte;
        logic prev_eeprom;
        logic prev_ack;
        logic prev_phy;
        logic prev_tick_lsb;
        logic [NCTX-1:0] prev_halt;
        logic [NCTX-1:0] ctx_blk;
        logic [NCTX-1:0] ctx_evt;
        logic long_run;
        logic [15:0] long_cnt;
        logic armed;
        logic seen_cs;
        logic gap_seen;
        logic lost_done;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic irq;
    } hie_state_t;

    hie_state_t st_r;
    hie_state_t st_nxt;
    logic [31:0] wmask;

    // Byte strobes widened to a bit mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_wmask
            assign wmask[gi*8 +: 8] = {8{st_r.wstrb[gi]}};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        logic [31:0] hw_set;
        logic [31:0] sw_set;
        logic [31:0] sw_clr;
        logic [31:0] wval;
        logic do_wr;
        logic ack_cond;
        logic boundary;
        logic cycle_start;
        logic [NCTX-1:0] halt_rise;
        hw_set = '0;
        sw_set = '0;
        sw_clr = '0;
        wval = '0;
        do_wr = 1'b0;
        ack_cond = 1'b0;
        boundary = 1'b0;
        cycle_start = 1'b0;
        halt_rise = '0;
        st_nxt = st_r;

        // Source edge detection; inputs come from units on this clock
        st_nxt.prev_eeprom = EEPROM_DONE_I;
        st_nxt.prev_phy = PHY_BYTE_VALID_I;
        st_nxt.prev_tick_lsb = TIMER_I[HIE_TICK_LSB];
        st_nxt.prev_halt = CTX_HALT_I;
        ack_cond = st_r.ack_en & (RXFIFO_PENDING_I | PHYRESP_BUSY_I | ACK_TARDY_SENT_I);
        st_nxt.prev_ack = ack_cond;

        hw_set[HIE_BIT_EEPROM] = EEPROM_DONE_I & ~st_r.prev_eeprom;
        hw_set[HIE_BIT_LATE_ACK] = ack_cond & ~st_r.prev_ack;
        if (PHY_BYTE_VALID_I & ~st_r.prev_phy)
        begin
            hw_set[HIE_BIT_PHY_BYTE] = 1'b1;
            st_nxt.phy_byte = PHY_BYTE_I;
        end

        // Boundary events follow the tick LSB toggling
        boundary = TIMER_I[HIE_TICK_LSB] ^ st_r.prev_tick_lsb;
        hw_set[HIE_BIT_BOUNDARY] = boundary;

        // Received cycle start checked against local seconds and tick fields
        if (CS_RX_I && ((CS_RX_SEC_I != TIMER_I[HIE_SEC_MSB:HIE_SEC_LSB]) ||
                        (CS_RX_TICK_I != TIMER_I[HIE_TICK_MSB:HIE_TICK_LSB])))
        begin
            hw_set[HIE_BIT_MISMATCH] = 1'b1;
        end

        // Missed period: flagged at most once per period
        cycle_start = CS_TX_START_I | CS_RX_I;
        if (boundary)
        begin
            if (st_r.armed && !st_r.seen_cs && !st_r.lost_done)
            begin
                hw_set[HIE_BIT_MISSED] = 1'b1;
            end
            st_nxt.armed = 1'b1;
            st_nxt.seen_cs = cycle_start;
            st_nxt.gap_seen = 1'b0;
            st_nxt.lost_done = 1'b0;
        end
        else if (st_r.armed)
        begin
            if (cycle_start)
            begin
                st_nxt.seen_cs = 1'b1;
            end
            else if (!st_r.seen_cs && !st_r.lost_done)
            begin
                // Early prediction: a second gap or a reset gap with no start between
                if (ARB_RESET_GAP_I || (SUBGAP_END_I && st_r.gap_seen))
                begin
                    hw_set[HIE_BIT_MISSED] = 1'b1;
                    st_nxt.lost_done = 1'b1;
                end
                else if (SUBGAP_END_I)
                begin
                    st_nxt.gap_seen = 1'b1;
                end
            end
        end

        // Overlong period, timed only while this node is period master
        if (!st_r.master_en)
        begin
            st_nxt.long_run = 1'b0;
            st_nxt.long_cnt = '0;
        end
        else if (CS_TX_START_I)
        begin
            st_nxt.long_run = 1'b1;
            st_nxt.long_cnt = '0;
        end
        else if (st_r.long_run && SUBGAP_END_I)
        begin
            st_nxt.long_run = 1'b0;
        end
        else if (st_r.long_run)
        begin
            st_nxt.long_cnt = st_r.long_cnt + 16'h0001;
            if (st_r.long_cnt >= 16'(OVERLONG_CYC))
            begin
                hw_set[HIE_BIT_OVERLONG] = 1'b1;
                st_nxt.long_run = 1'b0;
            end
        end

        // Halting errors: remember which contexts caused them
        halt_rise = CTX_HALT_I & ~st_r.prev_halt;
        hw_set[HIE_BIT_FATAL] = |halt_rise;
        st_nxt.ctx_blk = st_r.ctx_blk | halt_rise;
        st_nxt.ctx_evt = CTX_EVT_I & ~(st_r.ctx_blk & {NCTX{st_r.pend[HIE_BIT_FATAL]}});

        ////////////////////////////////////////////////////////////////////////////
        // AXI4-Lite write: address and data accepted in either order
        if (S_AXI_AWVALID_I && st_r.awready)
        begin
            st_nxt.aw_have = 1'b1;
            st_nxt.awaddr = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && st_r.wready)
        begin
            st_nxt.w_have = 1'b1;
            st_nxt.wdata = S_AXI_WDATA_I;
            st_nxt.wstrb = S_AXI_WSTRB_I;
        end
        if (st_r.bvalid && S_AXI_BREADY_I)
        begin
            st_nxt.bvalid = 1'b0;
        end
        if (st_r.aw_have && st_r.w_have && !st_r.bvalid)
        begin
            do_wr = 1'b1;
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = HIE_RESP_OKAY;
        end
        wval = st_r.wdata & wmask;
        if (do_wr)
        begin
            case ({st_r.awaddr[7:2], 2'b00})
                HIE_OFS_EVT_SET: sw_set = wval & HIE_EVT_IMPL;
                HIE_OFS_EVT_CLR: sw_clr = wval & HIE_EVT_IMPL;
                HIE_OFS_MASK: st_nxt.mask = (st_r.mask & ~wmask) | (wval & HIE_EVT_IMPL);
                HIE_OFS_LINK_CTRL:
                begin
                    if (wmask[HIE_BIT_MASTER_EN])
                    begin
                        st_nxt.master_en = wval[HIE_BIT_MASTER_EN];
                    end
                end
                HIE_OFS_HOST_CTRL:
                begin
                    if (wmask[HIE_BIT_ACK_EN])
                    begin
                        st_nxt.ack_en = wval[HIE_BIT_ACK_EN];
                    end
                end
                HIE_OFS_PHY_DATA: st_nxt.bresp = HIE_RESP_OKAY;
                default: st_nxt.bresp = HIE_RESP_SLVERR;
            endcase
        end

        // Hardware auto-clear beats a software write in the same cycle
        if (hw_set[HIE_BIT_OVERLONG])
        begin
            st_nxt.master_en = 1'b0;
        end

        // A set landing with its clear is kept
        st_nxt.pend = ((st_r.pend & ~sw_clr) | hw_set | sw_set) & HIE_EVT_IMPL;
        if (!st_nxt.pend[HIE_BIT_FATAL])
        begin
            st_nxt.ctx_blk = '0;
        end

        ////////////////////////////////////////////////////////////////////////////
        // AXI4-Lite read: one outstanding, answered the cycle after acceptance
        if (st_r.rvalid && S_AXI_RREADY_I)
        begin
            st_nxt.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID_I && st_r.arready)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = HIE_RESP_OKAY;
            st_nxt.rdata = '0;
            case ({S_AXI_ARADDR_I[7:2], 2'b00})
                HIE_OFS_EVT_SET: st_nxt.rdata = st_r.pend & HIE_EVT_IMPL;
                HIE_OFS_EVT_CLR: st_nxt.rdata = st_r.pend & st_r.mask & HIE_EVT_IMPL;
                HIE_OFS_MASK: st_nxt.rdata = st_r.mask;
                HIE_OFS_LINK_CTRL: st_nxt.rdata[HIE_BIT_MASTER_EN] = st_r.master_en;
                HIE_OFS_HOST_CTRL: st_nxt.rdata[HIE_BIT_ACK_EN] = st_r.ack_en;
                HIE_OFS_PHY_DATA: st_nxt.rdata[HIE_PHY_LSB +: 8] = st_r.phy_byte;
                default: st_nxt.rresp = HIE_RESP_SLVERR;
            endcase
        end

        // Ready only while nothing of that kind is held or awaiting response
        st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid && !(S_AXI_AWVALID_I && st_r.awready);
        st_nxt.wready = !st_nxt.w_have && !st_nxt.bvalid && !(S_AXI_WVALID_I && st_r.wready);
        st_nxt.arready = !st_nxt.rvalid;

        st_nxt.irq = |(st_nxt.pend & st_nxt.mask);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            st_r <= '0;
            st_r.pend <= HIE_RST_EVT;
            st_r.mask <= HIE_RST_MASK;
            st_r.master_en <= HIE_RST_MASTER_EN;
            st_r.ack_en <= HIE_RST_ACK_EN;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign S_AXI_AWREADY_O = st_r.awready;
    assign S_AXI_WREADY_O = st_r.wready;
    assign S_AXI_BVALID_O = st_r.bvalid;
    assign S_AXI_BRESP_O = st_r.bresp;
    assign S_AXI_ARREADY_O = st_r.arready;
    assign S_AXI_RVALID_O = st_r.rvalid;
    assign S_AXI_RRESP_O = st_r.rresp;
    assign S_AXI_RDATA_O = st_r.rdata;
    assign CTX_EVT_O = st_r.ctx_evt;
    assign PERIOD_MASTER_EN_O = st_r.master_en;
    assign IRQ_O = st_r.irq;

endmodule

`default_nettype wire

// >>> hie_event_ctrl_props.sv
// Checker: port-level timing and event rules of the interrupt event block
`default_nettype none
module hie_event_ctrl_props #(
    parameter int NCTX = 4,
    parameter int OVERLONG_CYC = 20
)(
    input wire logic CLK_I, RSTN_I,
    input wire logic S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I, S_AXI_WREADY_O,
    input wire logic S_AXI_BVALID_O, S_AXI_ARVALID_I, S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic S_AXI_RVALID_O, S_AXI_RREADY_I, IRQ_O,
    input wire logic [NCTX-1:0] CTX_HALT_I, CTX_EVT_I, CTX_EVT_O,
    input wire logic CS_TX_START_I, SUBGAP_END_I, PERIOD_MASTER_EN_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RSTN_I);
    ////////////////////////////////////////////////////////////////////////////////
    // Cycles since a start send with no gap end; saturates so it cannot wrap
    int ov_cnt_r;
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
            ov_cnt_r <= 0;
        else if (CS_TX_START_I)
            ov_cnt_r <= 1;
        else if (SUBGAP_END_I)
            ov_cnt_r <= 0;
        else if (ov_cnt_r != 0 && ov_cnt_r < 100000)
            ov_cnt_r <= ov_cnt_r + 1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_write_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
        && S_AXI_WREADY_O |-> ##2 S_AXI_BVALID_O) else $error("write response missing");
    a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("read data missing");
    a_rdata_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
        |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read data not held");
    a_reserved_zero: assert property (S_AXI_RVALID_O |-> !S_AXI_RDATA_O[31] && !S_AXI_RDATA_O[28])
        else $error("reserved bit reads one");
    // The clearing write and its response land on the same edge as the drop
    a_irq_fall_write: assert property ($fell(IRQ_O)
        |-> S_AXI_BVALID_O) else $error("irq dropped by itself");
    a_ctx_no_extra: assert property ((CTX_EVT_O & ~$past(CTX_EVT_I)) == '0)
        else $error("context event out of nowhere");
    a_ctx_blocked: assert property ($rose(CTX_HALT_I[0]) ##2 CTX_EVT_I[0] |=> !CTX_EVT_O[0])
        else $error("halted context event passed");
    a_master_cleared: assert property (ov_cnt_r > OVERLONG_CYC + 4 |-> !PERIOD_MASTER_EN_O)
        else $error("master enable kept after overlong period");
endmodule

bind hie_event_ctrl hie_event_ctrl_props #(.NCTX(NCTX), .OVERLONG_CYC(OVERLONG_CYC))
    u_hie_event_ctrl_props (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
    .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
    .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
    .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
    .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
    .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I), .IRQ_O(IRQ_O),
    .CTX_HALT_I(CTX_HALT_I), .CTX_EVT_I(CTX_EVT_I), .CTX_EVT_O(CTX_EVT_O),
    .CS_TX_START_I(CS_TX_START_I), .SUBGAP_END_I(SUBGAP_END_I),
    .PERIOD_MASTER_EN_O(PERIOD_MASTER_EN_O));
`default_nettype wire

// >>> hie_host_model.sv
// Host software model: AXI4-Lite master issuing single-word register accesses
`default_nettype none
module hie_host_model (
    input wire logic clk_i,
    output logic [7:0] awaddr_o, output logic awvalid_o, input wire logic awready_i,
    output logic [31:0] wdata_o, output logic [3:0] wstrb_o,
    output logic wvalid_o, input wire logic wready_i,
    input wire logic [1:0] bresp_i, input wire logic bvalid_i, output logic bready_o,
    output logic [7:0] araddr_o, output logic arvalid_o, input wire logic arready_i,
    input wire logic [31:0] rdata_i, input wire logic [1:0] rresp_i,
    input wire logic rvalid_i, output logic rready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
        wstrb_o = 4'hF;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Address and data go out together; each is dropped once its own ready is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        awaddr_o <= a;
        wdata_o <= d;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (awready_i)
                awvalid_o <= 1'b0;
            if (wready_i)
                wvalid_o <= 1'b0;
        end while (!bvalid_i);
        r = bresp_i;
        bready_o <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (arready_i)
                arvalid_o <= 1'b0;
        end while (!rvalid_i);
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> tb_hie_event_ctrl.sv
// Testbench: register, event source and blocking scenarios of the event block
`default_nettype none
module tb_hie_event_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OC = 20;
    logic clk, rstn, irq, men;
    logic [7:0] awaddr, araddr, pbyte;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, timer;
    logic [3:0] wstrb, halt, cevt, cevt_o;
    logic [1:0] bresp, rresp;
    logic [6:0] rxsec;
    logic [12:0] rxtick;
    logic [4:0] lv;  // eeprom done, rx fifo, resp busy, tardy, phy byte valid
    logic [3:0] pl;  // start send, start received, gap end, arb reset gap
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    hie_event_ctrl #(.NCTX(4), .OVERLONG_CYC(OC)) u_hie_event_ctrl (.CLK_I(clk), .RSTN_I(rstn),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
        .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .EEPROM_DONE_I(lv[0]),
        .RXFIFO_PENDING_I(lv[1]), .PHYRESP_BUSY_I(lv[2]), .ACK_TARDY_SENT_I(lv[3]),
        .PHY_BYTE_VALID_I(lv[4]), .PHY_BYTE_I(pbyte), .TIMER_I(timer), .CS_TX_START_I(pl[0]),
        .CS_RX_I(pl[1]), .CS_RX_SEC_I(rxsec), .CS_RX_TICK_I(rxtick), .SUBGAP_END_I(pl[2]),
        .ARB_RESET_GAP_I(pl[3]), .CTX_HALT_I(halt), .CTX_EVT_I(cevt), .CTX_EVT_O(cevt_o),
        .PERIOD_MASTER_EN_O(men), .IRQ_O(irq));

    hie_host_model u_hie_host_model (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid),
        .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
        .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
        .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
        .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wrk(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        u_hie_host_model.wr(a, d, r);
        chk(r, 2'h0);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, e);
        logic [31:0] d;
        logic [1:0] r;
        u_hie_host_model.rd(a, d, r);
        chk(r, 2'h0);
        chk(d & m, e);
    endtask

    // Reads only the bits under test, then clears them so later steps start clean
    task automatic seen(input logic [31:0] m, e);
        cyc(2);
        rdc(8'h80, m, e);
        wrk(8'h84, m);
    endtask

    task automatic lv_ev(input int i, input logic [31:0] m, e);
        lv[i] <= 1'b1;
        seen(m, e);
        lv[i] <= 1'b0;
        cyc(1);
    endtask

    task automatic pulse(input int i);
        pl[i] <= 1'b1;
        cyc(1);
        pl[i] <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_soft();
        logic [31:0] d;
        logic [1:0] r;
        rdc(8'h80, 32'hFFFF_FFFF, 32'h0000_0000);
        u_hie_host_model.rd(8'hA0, d, r);
        chk(r, 2'h2);
        u_hie_host_model.wr(8'hA0, 32'hFFFF_FFFF, r);
        chk(r, 2'h2);
        wrk(8'h80, 32'h2000_0000);
        rdc(8'h80, 32'hFFFF_FFFF, 32'h2000_0000);
        rdc(8'h84, 32'hFFFF_FFFF, 32'h0000_0000);
        wrk(8'h88, 32'h2000_0000);
        rdc(8'h84, 32'hFFFF_FFFF, 32'h2000_0000);
        chk(irq, 1'b1);
        wrk(8'h84, 32'h0000_0000);
        wrk(8'h80, 32'h9000_0000);
        rdc(8'h80, 32'hFFFF_FFFF, 32'h2000_0000);
        wrk(8'h84, 32'h2000_0000);
        rdc(8'h80, 32'hFFFF_FFFF, 32'h0000_0000);
        chk(irq, 1'b0);
    endtask

    task automatic t_events();
        lv_ev(0, 32'h4000_0000, 32'h4000_0000);
        lv_ev(1, 32'h0800_0000, 32'h0000_0000);
        wrk(8'h90, 32'h0000_0001);
        for (int i = 1; i < 4; i++)
            lv_ev(i, 32'h0800_0000, 32'h0800_0000);
        pbyte <= 8'hA5;
        lv_ev(4, 32'h0400_0000, 32'h0400_0000);
        rdc(8'h94, 32'h0000_00FF, 32'h0000_00A5);
        timer <= 32'h0000_1000;
        seen(32'h0010_0000, 32'h0010_0000);
        pulse(3);
        seen(32'h0040_0000, 32'h0040_0000);
        timer <= 32'h0000_0000;
        seen(32'h0010_0000, 32'h0010_0000);
        timer <= 32'h0000_1000;
        seen(32'h0050_0000, 32'h0050_0000);
        rxtick <= 13'h0001;
        pulse(1);
        seen(32'h0080_0000, 32'h0000_0000);
        rxtick <= 13'h0002;
        pulse(1);
        seen(32'h0080_0000, 32'h0080_0000);
        // Two gaps with no start between predict a missed period
        timer <= 32'h0000_0000;
        cyc(1);
        pulse(2);
        cyc(1);
        pulse(2);
        seen(32'h0050_0000, 32'h0050_0000);
    endtask

    task automatic t_fatal();
        halt <= 4'h1;
        cyc(2);
        cevt <= 4'hF;
        cyc(1);
        cevt <= 4'h0;
        cyc(1);
        chk(cevt_o, 4'hE);
        seen(32'h0100_0000, 32'h0100_0000);
        halt <= 4'h0;
        cevt <= 4'hF;
        cyc(1);
        cevt <= 4'h0;
        cyc(1);
        chk(cevt_o, 4'hF);
    endtask

    task automatic t_over();
        wrk(8'h8C, 32'h0020_0000);
        chk(men, 1'b1);
        pulse(0);
        cyc(5);
        pulse(2);
        cyc(OC + 6);
        rdc(8'h80, 32'h0200_0000, 32'h0000_0000);
        chk(men, 1'b1);
        pulse(0);
        cyc(OC + 6);
        chk(men, 1'b0);
        seen(32'h0200_0000, 32'h0200_0000);
        pulse(0);
        cyc(OC + 6);
        rdc(8'h80, 32'h0200_0000, 32'h0000_0000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            $display("mismatch at %0t: run timed out", $time);
            close_out();
        end
    end

    initial
    begin
        rstn = 1'b0;
        {lv, pl, pbyte, timer, rxsec, rxtick, halt, cevt} = '0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        cyc(2);
        t_soft();
        t_events();
        t_fatal();
        t_over();
        close_out();
    end
endmodule
`default_nettype wire
